// *** rtl/ldets_pkg.sv ***
// Constants shared by the LED diagnostics-enable / threshold-select bank.
// Assumes registers are reached as words: byte address = 4 * index.
package ldets_pkg;

    // ==========================================================
    // Register indices and byte addresses
    localparam int          NUM_REGS        = 7;
    localparam logic [7:0]  IDX_DIAG_AB     = 8'h70;
    localparam logic [7:0]  IDX_DIAG_CD     = 8'h71;
    localparam logic [7:0]  IDX_DIAG_EF     = 8'h72;
    localparam logic [7:0]  IDX_DIAG_GH     = 8'h73;
    localparam logic [7:0]  IDX_THSEL_AB    = 8'h74;
    localparam logic [7:0]  IDX_TH_ZERO     = 8'h78;
    localparam logic [7:0]  IDX_TH_ONE      = 8'h79;
    localparam logic [7:0]  SLOT_IDX [NUM_REGS] = '{
        IDX_DIAG_AB, IDX_DIAG_CD, IDX_DIAG_EF, IDX_DIAG_GH,
        IDX_THSEL_AB, IDX_TH_ZERO, IDX_TH_ONE};
    localparam logic [1:0]  ADDR_LSB_PAD    = 2'h0;

    // ==========================================================
    // Slots inside the bank
    localparam int          SLOT_DIAG_AB    = 0;
    localparam int          SLOT_DIAG_GH    = 3;
    localparam int          SLOT_THSEL_AB   = 4;
    localparam int          SLOT_TH_ZERO    = 5;
    localparam int          SLOT_TH_ONE     = 6;

    // ==========================================================
    // Field layout of the channel-group registers
    localparam int          GRP_W           = 3;
    localparam int          LOW_GRP_LSB     = 0;
    localparam int          HIGH_GRP_LSB    = 4;
    localparam logic [7:0]  GRP_REG_MASK    = 8'h77;
    localparam logic [7:0]  REG_RESET_VAL   = 8'h00;
    localparam int          NUM_GROUPS      = 8;
    localparam int          NUM_CHANNELS    = NUM_GROUPS * GRP_W;

    // ==========================================================
    // Bus constants
    localparam logic [31:0] RDATA_UNMAPPED  = 32'h0000_0000;
    localparam logic        HRESP_OKAY      = 1'h0;

endpackage

// *** rtl/ldets_nvm_load.sv ***
// Sequencer that copies the nonvolatile image into the bank after reset.
// Assumes the memory drives nvmData for nvmAddr in each cycle it raises nvmAck.
module ldets_nvm_load
    import ldets_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    // Nonvolatile memory port
    output logic             nvmReq,
    output logic [7:0]       nvmAddr,
    input  wire logic        nvmAck,
    input  wire logic [7:0]  nvmData,
    // Bank load port
    output logic             loadWe,
    output logic [2:0]       loadSlot,
    output logic [7:0]       loadData,
    output logic             loadBusy
);

    typedef enum logic [1:0] {
        LD_FETCH = 2'b01,
        LD_DONE  = 2'b10
    } ldets_ld_state_t;

    ldets_ld_state_t state_q, state_d;
    logic [2:0]      slot_q, slot_d;

    // ==========================================================
    // Walk all slots once, one memory word each
    always_comb begin
        state_d = state_q;
        slot_d  = slot_q;
        unique case (state_q)
            LD_FETCH: begin
                if (nvmAck) begin
                    if (slot_q == 3'(NUM_REGS - 1)) begin
                        state_d = LD_DONE;
                    end else begin
                        slot_d = slot_q + 3'h1;
                    end
                end
            end
            LD_DONE: begin
                state_d = LD_DONE;
            end
            default: begin
                state_d = LD_FETCH;
                slot_d  = 3'h0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= LD_FETCH;
            slot_q  <= 3'h0;
        end else begin
            state_q <= state_d;
            slot_q  <= slot_d;
        end
    end

    assign loadBusy = (state_q != LD_DONE);
    assign nvmReq   = (state_q == LD_FETCH);
    assign nvmAddr  = SLOT_IDX[slot_q];
    assign loadWe   = nvmReq && nvmAck;
    assign loadSlot = slot_q;
    assign loadData = nvmData;

endmodule // ldets_nvm_load

// *** rtl/ldets_ahb_slave.sv ***
// AHB-Lite slave front end: writes complete with no wait state, reads
// with one; every data phase stalls while the bank is being loaded.
module ldets_ahb_slave
    import ldets_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    // AHB-Lite
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Bank side
    input  wire logic        busy,
    output logic             regWe,
    output logic [31:0]      regAddr,
    output logic [31:0]      regWdata,
    input  wire logic [31:0] regRdata
);

    logic        dataPhase_q, dataPhase_d;
    logic        write_q,     write_d;
    logic [31:0] addr_q,      addr_d;
    logic        rdReady_q,   rdReady_d;
    logic [31:0] rdata_q,     rdata_d;
    logic        accept;

    // ==========================================================
    // Phase tracking
    assign accept    = hsel && htrans[1] && hready;
    assign hreadyout = !dataPhase_q
                       || (!busy && (write_q || rdReady_q));
    assign regWe     = dataPhase_q && write_q && !busy;
    assign regAddr   = addr_q;
    assign regWdata  = hwdata;
    assign hresp     = HRESP_OKAY;
    assign hrdata    = rdata_q;

    always_comb begin
        dataPhase_d = dataPhase_q;
        write_d     = write_q;
        addr_d      = addr_q;
        rdReady_d   = 1'b0;
        rdata_d     = rdata_q;
        if (dataPhase_q && !write_q && !busy && !rdReady_q) begin
            rdReady_d = 1'b1;
            rdata_d   = regRdata;
        end
        if (hreadyout) begin
            dataPhase_d = 1'b0;
        end
        if (accept) begin
            dataPhase_d = 1'b1;
            write_d     = hwrite;
            addr_d      = haddr;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            dataPhase_q <= 1'b0;
            write_q     <= 1'b0;
            addr_q      <= 32'h0000_0000;
            rdReady_q   <= 1'b0;
            rdata_q     <= 32'h0000_0000;
        end else begin
            dataPhase_q <= dataPhase_d;
            write_q     <= write_d;
            addr_q      <= addr_d;
            rdReady_q   <= rdReady_d;
            rdata_q     <= rdata_d;
        end
    end

endmodule // ldets_ahb_slave

// *** rtl/ldets_bank.sv ***
// Configuration bank: per-channel diagnostics enables, short-threshold
// selects for groups A and B, and the two short-threshold values.
// Assumes one AHB-Lite master and a nonvolatile memory read port.
//
// Notes on behaviour
// - Word 71h: bits 6..4 enable D2..D0, bits 2..0 enable C2..C0.
// - Word 72h: bits 6..4 enable F2..F0, bits 2..0 enable E2..E0.
// - Word 73h: bits 6..4 enable H2..H0, bits 2..0 enable G2..G0.
// - Enable bits read and write; zero disables, one enables diagnostics.
// - After every reset all writable bits load from nonvolatile memory.
// - Word 74h: bits 6..4 select B2..B0, bits 2..0 select A2..A0.
// - Select bits read and write; zero picks threshold zero, one one.
// - Threshold zero value lives at 78h, threshold one at 79h.
// - Word 70h holds enables for groups A and B, same layout.
//
// The implementer's own choice: the AHB-Lite register port.
module ldets_bank
    import ldets_pkg::*;
#(
    parameter int TH_W = 8
) (
    // Clock and reset
    input  wire logic                    sys_clk,
    input  wire logic                    arst_n,
    // AHB-Lite
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic                         hreadyout,
    output logic                         hresp,
    output logic [31:0]                  hrdata,
    // Nonvolatile memory
    output logic                         nvmReq,
    output logic [7:0]                   nvmAddr,
    input  wire logic                    nvmAck,
    input  wire logic [7:0]              nvmData,
    // Settings towards the diagnostic engine
    output logic [NUM_CHANNELS-1:0]      chanDiagEnable,
    output logic [2*GRP_W-1:0]           chanShortThresholdSelect,
    output logic [TH_W-1:0]              shortThresholdZeroValue,
    output logic [TH_W-1:0]              shortThresholdOneValue,
    output logic                         loadBusy
);

    // ==========================================================
    // Elaboration checks
    if (TH_W < 1 || TH_W > 8) begin : g_bad_width
        $error("TH_W must lie between 1 and 8");
    end

    localparam logic [7:0] TH_MASK = 8'((9'h1 << TH_W) - 9'h1);

    logic [7:0]  regs_q [NUM_REGS];
    logic [7:0]  regs_d [NUM_REGS];
    logic        loadWe;
    logic [2:0]  loadSlot;
    logic [7:0]  loadData;
    logic        regWe;
    logic [31:0] regAddr;
    logic [31:0] regWdata;
    logic [31:0] regRdata;
    logic        hit;
    logic [2:0]  hitSlot;

    // ==========================================================
    // Bus front end and nonvolatile loader
    ldets_ahb_slave ldets_ahb_slave_inst (
        .sys_clk   (sys_clk),
        .arst_n    (arst_n),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hwdata    (hwdata),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata),
        .busy      (loadBusy),
        .regWe     (regWe),
        .regAddr   (regAddr),
        .regWdata  (regWdata),
        .regRdata  (regRdata)
    );

    ldets_nvm_load ldets_nvm_load_inst (
        .sys_clk  (sys_clk),
        .arst_n   (arst_n),
        .nvmReq   (nvmReq),
        .nvmAddr  (nvmAddr),
        .nvmAck   (nvmAck),
        .nvmData  (nvmData),
        .loadWe   (loadWe),
        .loadSlot (loadSlot),
        .loadData (loadData),
        .loadBusy (loadBusy)
    );

    // ==========================================================
    // Writable-bit mask per slot
    function automatic logic [7:0] slotMask(input int slot);
        if (slot >= SLOT_TH_ZERO) begin
            return TH_MASK;
        end
        return GRP_REG_MASK;
    endfunction

    // ==========================================================
    // Address decode: word index times four
    always_comb begin
        hit     = 1'b0;
        hitSlot = 3'h0;
        for (int s = 0; s < NUM_REGS; s++) begin
            if (regAddr == {22'h0, SLOT_IDX[s], ADDR_LSB_PAD}) begin
                hit     = 1'b1;
                hitSlot = 3'(s);
            end
        end
    end

    // ==========================================================
    // Register storage; sizes other than a word are treated as a word
    always_comb begin
        for (int s = 0; s < NUM_REGS; s++) begin
            regs_d[s] = regs_q[s];
            if (loadWe && loadSlot == 3'(s)) begin
                regs_d[s] = loadData & slotMask(s);
            end
            if (regWe && hit && hitSlot == 3'(s)) begin
                regs_d[s] = regWdata[7:0] & slotMask(s);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int s = 0; s < NUM_REGS; s++) begin
                regs_q[s] <= REG_RESET_VAL;
            end
        end else begin
            for (int s = 0; s < NUM_REGS; s++) begin
                regs_q[s] <= regs_d[s];
            end
        end
    end

    // Read back shows stored bits; reserved bits are stored as zero
    assign regRdata = hit ? {24'h0, regs_q[hitSlot]}
                          : RDATA_UNMAPPED;

    // ==========================================================
    // Channel fan-out: group g sits in word g/2, low or high half
    for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_grp
        localparam int W   = SLOT_DIAG_AB + g / 2;
        localparam int LSB = (g % 2 == 0) ? LOW_GRP_LSB : HIGH_GRP_LSB;
        assign chanDiagEnable[g*GRP_W +: GRP_W] =
            regs_q[W][LSB +: GRP_W];
    end

    assign chanShortThresholdSelect = {
        regs_q[SLOT_THSEL_AB][HIGH_GRP_LSB +: GRP_W],
        regs_q[SLOT_THSEL_AB][LOW_GRP_LSB +: GRP_W]};
    assign shortThresholdZeroValue =
        regs_q[SLOT_TH_ZERO][TH_W-1:0];
    assign shortThresholdOneValue  =
        regs_q[SLOT_TH_ONE][TH_W-1:0];

endmodule // ldets_bank

// *** sim/ldets_bank_properties.sv ***
// Concurrent checks on the ports of the configuration bank.
// Assumes one AHB-Lite master with hready tied to hreadyout.
module ldets_bank_properties
    import ldets_pkg::*;
#(
    parameter int TH_W = 8
) (
    // Clock and reset
    input wire logic                    sys_clk,
    input wire logic                    arst_n,
    // AHB-Lite
    input wire logic                    hsel,
    input wire logic [31:0]             haddr,
    input wire logic [1:0]              htrans,
    input wire logic                    hwrite,
    input wire logic [31:0]             hwdata,
    input wire logic                    hready,
    input wire logic                    hreadyout,
    input wire logic                    hresp,
    input wire logic [31:0]             hrdata,
    // Nonvolatile memory and settings
    input wire logic                    nvmReq,
    input wire logic [7:0]              nvmAddr,
    input wire logic                    nvmAck,
    input wire logic [7:0]              nvmData,
    input wire logic [NUM_CHANNELS-1:0] chanDiagEnable,
    input wire logic [2*GRP_W-1:0]      chanShortThresholdSelect,
    input wire logic [TH_W-1:0]         shortThresholdZeroValue,
    input wire logic [TH_W-1:0]         shortThresholdOneValue,
    input wire logic                    loadBusy
);
    timeunit 1ns;
    timeprecision 1ns;

    // ====================
    // Data phase tracking
    logic       phQ;
    logic       wrQ;
    logic [7:0] idxQ;
    logic       wrDone;
    logic       rdDone;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            phQ  <= 1'b0;
            wrQ  <= 1'b0;
            idxQ <= 8'h00;
        end else if (hsel && htrans[1] && hready) begin
            phQ  <= 1'b1;
            wrQ  <= hwrite;
            idxQ <= (haddr[31:10] == 22'h0) ? haddr[9:2] : 8'h00;
        end else if (hready) begin
            phQ  <= 1'b0;
        end
    end
    assign wrDone = phQ && wrQ && hreadyout;
    assign rdDone = phQ && !wrQ && hreadyout;

    // ====================
    // Properties
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    sequence s_wr(logic [7:0] i);
        wrDone && idxQ == i;
    endsequence
    sequence s_take(logic [7:0] i);
        nvmReq && nvmAck && nvmAddr == i;
    endsequence

    a_ab_write: assert property (s_wr(IDX_DIAG_AB) |=>
        chanDiagEnable[5:0] == $past({hwdata[6:4], hwdata[2:0]}))
        else $error("Group A/B enables differ from write");
    a_cd_write: assert property (s_wr(IDX_DIAG_CD) |=>
        chanDiagEnable[11:6] == $past({hwdata[6:4], hwdata[2:0]}))
        else $error("Group C/D enables differ from write");
    a_ef_write: assert property (s_wr(IDX_DIAG_EF) |=>
        chanDiagEnable[17:12] == $past({hwdata[6:4], hwdata[2:0]}))
        else $error("Group E/F enables differ from write");
    a_gh_write: assert property (s_wr(IDX_DIAG_GH) |=>
        chanDiagEnable[23:18] == $past({hwdata[6:4], hwdata[2:0]}))
        else $error("Group G/H enables differ from write");
    a_sel_write: assert property (s_wr(IDX_THSEL_AB) |=>
        chanShortThresholdSelect == $past({hwdata[6:4], hwdata[2:0]}))
        else $error("Threshold selects differ from write");
    a_th_write: assert property (s_wr(IDX_TH_ZERO) |=>
        shortThresholdZeroValue == $past(hwdata[TH_W-1:0]))
        else $error("Threshold zero value differs from write");
    a_th_one_write: assert property (s_wr(IDX_TH_ONE) |=>
        shortThresholdOneValue == $past(hwdata[TH_W-1:0]))
        else $error("Threshold one value differs from write");
    a_load_gh: assert property (s_take(IDX_DIAG_GH) |=>
        chanDiagEnable[23:18] == $past({nvmData[6:4], nvmData[2:0]}))
        else $error("Loaded G/H enables differ from memory");
    a_load_end: assert property (s_take(IDX_TH_ONE) |=>
        !nvmReq && !loadBusy)
        else $error("Image load did not end after last word");
    a_rsvd_zero: assert property (rdDone && idxQ >= IDX_DIAG_AB
        && idxQ <= IDX_THSEL_AB |-> !hrdata[7] && !hrdata[3])
        else $error("Reserved bits read nonzero");
    a_unmapped_zero: assert property (rdDone && idxQ == 8'h75
        |-> hrdata == RDATA_UNMAPPED)
        else $error("Unmapped read returned data");
    a_resp_okay: assert property (hresp == HRESP_OKAY)
        else $error("Response not OKAY");
endmodule // ldets_bank_properties

bind ldets_bank ldets_bank_properties #(.TH_W(TH_W))
    ldets_bank_properties_inst (
    .sys_clk(sys_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .nvmReq(nvmReq), .nvmAddr(nvmAddr), .nvmAck(nvmAck), .nvmData(nvmData),
    .chanDiagEnable(chanDiagEnable), .loadBusy(loadBusy),
    .chanShortThresholdSelect(chanShortThresholdSelect),
    .shortThresholdZeroValue(shortThresholdZeroValue),
    .shortThresholdOneValue(shortThresholdOneValue));

// *** sim/ldets_tb.sv ***
// Self-checking bench for the configuration bank over AHB-Lite.
// Assumes the bank is the only slave; the bench plays the memory.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import ldets_pkg::*;

    logic        sys_clk = 1'b0;
    logic        arst_n  = 1'b0;
    logic        hsel    = 1'b0;
    logic [31:0] haddr   = 32'h0;
    logic [1:0]  htrans  = 2'h0;
    logic        hwrite  = 1'b0;
    logic [31:0] hwdata  = 32'h0;
    logic        nvmAck  = 1'b0;
    logic [7:0]  nvmData = 8'h00;
    logic        hreadyout, hresp, nvmReq, loadBusy;
    logic [31:0] hrdata, rd;
    logic [7:0]  nvmAddr, thZero, thOne;
    logic [23:0] diagEn;
    logic [5:0]  thSel;
    logic [7:0]  pats [4] = '{8'hff, 8'h00, 8'h5a, 8'ha5};
    int          fail_count = 0;
    int          total_checks = 0;

    always #50 sys_clk = ~sys_clk;

    // Memory acks every other cycle and returns the inverted index
    always @(posedge sys_clk) begin
        nvmAck  <= nvmReq && !nvmAck;
        nvmData <= ~nvmAddr;
    end

    ldets_bank #(.TH_W(8)) ldets_bank_inst (
        .sys_clk(sys_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .nvmReq(nvmReq), .nvmAddr(nvmAddr),
        .nvmAck(nvmAck), .nvmData(nvmData), .chanDiagEnable(diagEn),
        .chanShortThresholdSelect(thSel), .shortThresholdZeroValue(thZero),
        .shortThresholdOneValue(thOne), .loadBusy(loadBusy));

    function automatic logic [31:0] expv(input logic [7:0] i, d);
        return {24'h0, (i >= IDX_TH_ZERO) ? d : (d & GRP_REG_MASK)};
    endfunction

    function automatic logic [5:0] pack(input logic [7:0] b);
        return {b[6:4], b[2:0]};
    endfunction

    task automatic chk(input logic [31:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic ahb(input logic w, input logic [7:0] i, d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {22'h0, i, 2'h0};
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic reboot();
        arst_n <= 1'b0;
        repeat (16) @(posedge sys_clk);
        arst_n <= 1'b1;
        while (loadBusy !== 1'b0) @(posedge sys_clk);
        for (int k = 0; k < NUM_REGS; k++) begin
            ahb(1'b0, SLOT_IDX[k], 8'h00);
            chk(rd, expv(SLOT_IDX[k], ~SLOT_IDX[k]));
        end
        chk({8'h0, diagEn}, {8'h0, pack(8'h8c), pack(8'h8d),
            pack(8'h8e), pack(8'h8f)});
        chk({26'h0, thSel}, {26'h0, pack(8'h8b)});
        chk({16'h0, thOne, thZero}, 32'h0000_8687);
    endtask

    task automatic results();
        $display("Checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ====================
    // Watchdog
    initial begin
        repeat (5000) @(posedge sys_clk);
        fail_count++;
        results();
    end

    // ====================
    // Tests
    initial begin
        reboot();
        for (int p = 0; p < 4; p++) begin
            for (int k = 0; k < NUM_REGS; k++) begin
                ahb(1'b1, SLOT_IDX[k], pats[p]);
                ahb(1'b0, SLOT_IDX[k], 8'h00);
                chk(rd, expv(SLOT_IDX[k], pats[p]));
            end
            chk({8'h0, diagEn},
                {8'h0, {4{pack(pats[p])}}});
            chk({26'h0, thSel}, {26'h0, pack(pats[p])});
            chk({16'h0, thOne, thZero}, {16'h0, {2{pats[p]}}});
        end
        // Unmapped word: write ignored, reads zero
        ahb(1'b1, 8'h75, 8'hff);
        ahb(1'b0, 8'h75, 8'h00);
        chk(rd, RDATA_UNMAPPED);
        ahb(1'b0, 8'h00, 8'h00);
        chk(rd, RDATA_UNMAPPED);
        chk({8'h0, diagEn}, {8'h0, {4{pack(8'ha5)}}});
        // Second reset must reload the image over the written values
        reboot();
        results();
    end
endmodule // tb
